// *** inc/rail_seq_pkg.sv ***
// Shared constants, types and step decoding for the rail strobe sequencer
`default_nettype none

package rail_seq_pkg;

    // ****************************************************************
    // Register subaddresses and reset values
    // ****************************************************************
    localparam logic [7:0] ADDR_BUCK12     = 8'h22;
    localparam logic [7:0] ADDR_BB_BUCK3   = 8'h23;
    localparam logic [7:0] ADDR_SLOT       = 8'h24;
    localparam logic [7:0] ADDR_LINEAR     = 8'h25;
    localparam logic [7:0] ADDR_GPO        = 8'h26;

    localparam logic [7:0] RST_BUCK12      = 8'h98;
    localparam logic [7:0] RST_BB_BUCK3    = 8'h75;
    localparam logic [7:0] RST_SLOT        = 8'h12;
    localparam logic [7:0] RST_LINEAR      = 8'h63;
    localparam logic [7:0] RST_GPO         = 8'h03;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int         FIELD_LO_LSB    = 0;
    localparam int         FIELD_HI_LSB    = 4;
    localparam int         NUM_RAILS       = 7;
    localparam int         RAIL_BUCK1      = 0;
    localparam int         RAIL_BUCK2      = 1;
    localparam int         RAIL_BUCK3      = 2;
    localparam int         RAIL_BUCKBOOST  = 3;
    localparam int         RAIL_LINEAR     = 4;
    localparam int         RAIL_GPO1       = 5;
    localparam int         RAIL_GENERAL_OUTPUT_TWO       = 6;

    // ****************************************************************
    // Steps and timing
    // ****************************************************************
    localparam logic [3:0] STEP_FIRST      = 4'h1;
    localparam logic [3:0] STEP_LAST       = 4'hA;
    localparam logic [3:0] CODE_MIN        = 4'h3;
    localparam logic [3:0] CODE_MAX        = 4'hA;
    localparam int         DELAY_W         = 24;
    localparam int         CLK_MHZ         = 200;
    localparam int         SHORT_DELAY_MS  = 2;
    localparam int         LONG_DELAY_MS   = 5;
    localparam int         PD_DELAY_FACTOR = 10;
    localparam int         SHORT_DELAY_CYCLES =
        SHORT_DELAY_MS * 1000 * CLK_MHZ;
    localparam int         LONG_DELAY_CYCLES =
        LONG_DELAY_MS * 1000 * CLK_MHZ;

    typedef enum logic [2:0] {
        SEQ_OFF,
        SEQ_STROBE_UP,
        SEQ_WAIT_UP,
        SEQ_ON,
        SEQ_STROBE_DN,
        SEQ_WAIT_DN
    } seq_state_t;

    function automatic logic code_sequenced(input logic [3:0] code);
        return (code >= CODE_MIN) && (code <= CODE_MAX);
    endfunction : code_sequenced

    function automatic logic step_hit(input logic [3:0] code,
                                      input logic [3:0] step);
        return code_sequenced(code) && (code == step);
    endfunction : step_hit

endpackage : rail_seq_pkg

`default_nettype wire

// *** rtl/rail_step_match.sv ***
// Per-rail decode of assignment codes against the current step
`timescale 1ns/1ps
`default_nettype none

module rail_step_match (
    input  wire logic [27:0] i_codes,
    input  wire logic [3:0]  i_step,
    output logic      [6:0]  o_hit,
    output logic      [6:0]  o_sequenced
);

    always_comb begin
        for (int i = 0; i < rail_seq_pkg::NUM_RAILS; i++) begin
            o_hit[i]       = rail_seq_pkg::step_hit(i_codes[4*i +: 4],
                                                    i_step);
            o_sequenced[i] =
                rail_seq_pkg::code_sequenced(i_codes[4*i +: 4]);
        end
    end

endmodule : rail_step_match

`default_nettype wire

// *** rtl/step_delay_timer.sv ***
// Down counter that times the gap between two sequencer steps
`timescale 1ns/1ps
`default_nettype none

module step_delay_timer (
    input  wire logic        i_ref_clk,
    input  wire logic        i_reset,
    input  wire logic        i_load,
    input  wire logic [23:0] i_cycles,
    output logic             o_done
);

    typedef struct packed {
        logic [23:0] count;
    } timer_state_t;

    timer_state_t q;
    timer_state_t next_q;

    always_comb begin
        next_q = q;
        if (i_load) begin
            next_q.count = i_cycles;
        end else if (q.count != 24'h00_0000) begin
            next_q.count = q.count - 24'h00_0001;
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    // Last count of a running gap; a reload in the same cycle wins
    assign o_done = (q.count == 24'h00_0001) && !i_load;

endmodule : step_delay_timer

`default_nettype wire

// *** rtl/rail_strobe_assignment.sv ***
// Rail step assignment registers and the ten-step rail sequencer
`timescale 1ns/1ps
`default_nettype none

// Operation
// - A field coded 3h to Ah enables its rail at the step of that number.
// - Codes 0h-2h and Bh-Fh keep the rail out of the sequencer's reach.
// - First buck field is bits 3-0 at 0x22, read-write, reset 8h.
// - Buck-boost field is bits 7-4 at 0x23, read-write, reset 7h.
// - Third buck field is bits 3-0 at 0x23, read-write, reset 5h.
// - Linear rail field is bits 3-0 at 0x25, read-write, reset 3h.
// - Second general output field is bits 7-4 at 0x26, reset 0h.
// - Register 0x23 is decoded and resets to 0x75.
// - At 0x24 bits 7-6, 3-2 read zero; 5-4 reset 1h, 1-0 reset 2h.
// - At 0x25 the writable upper nibble resets 6h, whole value 0x63.
// - Register 0x26 is decoded and resets to 0x03.
// - Gap after each step is 2 ms when its select bit is 0, else 5 ms.
// - The factor bit stretches every gap tenfold, in power-down only.
module rail_strobe_assignment #(
    parameter logic [23:0] SHORT_DELAY_CYCLES =
        24'(rail_seq_pkg::SHORT_DELAY_CYCLES),
    parameter logic [23:0] LONG_DELAY_CYCLES =
        24'(rail_seq_pkg::LONG_DELAY_CYCLES)
) (
    input  wire logic       i_ref_clk,
    input  wire logic       i_reset,
    input  wire logic [7:0] i_reg_addr,
    input  wire logic [7:0] i_reg_wdata,
    input  wire logic       i_reg_write,
    input  wire logic       i_reg_read,
    input  wire logic       i_unlocked,
    input  wire logic [8:0] i_step_delay_select,
    input  wire logic       i_power_down_delay_factor,
    input  wire logic       i_power_request,
    input  wire logic [6:0] i_direct_enable,
    output logic      [7:0] o_reg_rdata,
    output logic      [6:0] o_rail_enable,
    output logic      [3:0] o_seq_step,
    output logic            o_seq_busy
);

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        rail_seq_pkg::seq_state_t fsm;
        logic [3:0]               step;
        logic [6:0]               rail;
        logic [7:0]               buck12;
        logic [7:0]               bb_buck3;
        logic [3:0]               slot;
        logic [7:0]               linear;
        logic [7:0]               gpo;
        logic [7:0]               rdata;
    } state_t;

    localparam state_t RESET_STATE = '{
        fsm:      rail_seq_pkg::SEQ_OFF,
        step:     rail_seq_pkg::STEP_FIRST,
        rail:     7'h00,
        buck12:   rail_seq_pkg::RST_BUCK12,
        bb_buck3: rail_seq_pkg::RST_BB_BUCK3,
        slot:     {rail_seq_pkg::RST_SLOT[5:4],
                   rail_seq_pkg::RST_SLOT[1:0]},
        linear:   rail_seq_pkg::RST_LINEAR,
        gpo:      rail_seq_pkg::RST_GPO,
        rdata:    8'h00
    };

    state_t      q;
    state_t      next_q;
    logic [27:0] codes;
    logic [6:0]  hit;
    logic [6:0]  sequenced;
    logic        t_load;
    logic [23:0] t_cycles;
    logic        t_done;

    // Gap k sits between step k and step k+1
    function automatic logic [23:0] gap_cycles(input logic [3:0] k,
                                               input logic [8:0] sel,
                                               input logic       down,
                                               input logic       fctr);
        logic [23:0] base;
        base = sel[4'(k - 4'h1)] ? LONG_DELAY_CYCLES
                                 : SHORT_DELAY_CYCLES;
        if (down && fctr) begin
            base = 24'(base * rail_seq_pkg::PD_DELAY_FACTOR);
        end
        return base;
    endfunction : gap_cycles

    // ****************************************************************
    // Step decode and gap timer
    // ****************************************************************
    assign codes = {q.gpo[7:4], q.gpo[3:0], q.linear[3:0],
                    q.bb_buck3[7:4], q.bb_buck3[3:0],
                    q.buck12[7:4], q.buck12[3:0]};

    rail_step_match u_match (
        .i_codes     (codes),
        .i_step      (q.step),
        .o_hit       (hit),
        .o_sequenced (sequenced)
    );

    step_delay_timer u_timer (
        .i_ref_clk (i_ref_clk),
        .i_reset   (i_reset),
        .i_load    (t_load),
        .i_cycles  (t_cycles),
        .o_done    (t_done)
    );

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        next_q   = q;
        t_load   = 1'b0;
        t_cycles = 24'h00_0000;

        if (i_reg_write && i_unlocked) begin
            case (i_reg_addr)
                rail_seq_pkg::ADDR_BUCK12:   next_q.buck12 = i_reg_wdata;
                rail_seq_pkg::ADDR_BB_BUCK3: next_q.bb_buck3 = i_reg_wdata;
                rail_seq_pkg::ADDR_SLOT:     next_q.slot =
                    {i_reg_wdata[5:4], i_reg_wdata[1:0]};
                rail_seq_pkg::ADDR_LINEAR:   next_q.linear = i_reg_wdata;
                rail_seq_pkg::ADDR_GPO:      next_q.gpo = i_reg_wdata;
                default:                     next_q.rdata = q.rdata;
            endcase
        end

        if (i_reg_read) begin
            case (i_reg_addr)
                rail_seq_pkg::ADDR_BUCK12:   next_q.rdata = q.buck12;
                rail_seq_pkg::ADDR_BB_BUCK3: next_q.rdata = q.bb_buck3;
                rail_seq_pkg::ADDR_SLOT:     next_q.rdata =
                    {2'h0, q.slot[3:2], 2'h0, q.slot[1:0]};
                rail_seq_pkg::ADDR_LINEAR:   next_q.rdata = q.linear;
                rail_seq_pkg::ADDR_GPO:      next_q.rdata = q.gpo;
                default:                     next_q.rdata = 8'h00;
            endcase
        end

        unique case (q.fsm)
            rail_seq_pkg::SEQ_OFF: begin
                if (i_power_request) begin
                    next_q.step = rail_seq_pkg::STEP_FIRST;
                    next_q.fsm  = rail_seq_pkg::SEQ_STROBE_UP;
                end
            end
            rail_seq_pkg::SEQ_STROBE_UP: begin
                next_q.rail = q.rail | hit;
                if (q.step == rail_seq_pkg::STEP_LAST) begin
                    next_q.fsm = rail_seq_pkg::SEQ_ON;
                end else begin
                    t_load     = 1'b1;
                    t_cycles   = gap_cycles(q.step, i_step_delay_select,
                                            1'b0, 1'b0);
                    next_q.fsm = rail_seq_pkg::SEQ_WAIT_UP;
                end
            end
            rail_seq_pkg::SEQ_WAIT_UP: begin
                if (!i_power_request) begin
                    next_q.fsm = rail_seq_pkg::SEQ_STROBE_DN;
                end else if (t_done) begin
                    next_q.step = q.step + 4'h1;
                    next_q.fsm  = rail_seq_pkg::SEQ_STROBE_UP;
                end
            end
            rail_seq_pkg::SEQ_ON: begin
                if (!i_power_request) begin
                    next_q.step = rail_seq_pkg::STEP_LAST;
                    next_q.fsm  = rail_seq_pkg::SEQ_STROBE_DN;
                end
            end
            rail_seq_pkg::SEQ_STROBE_DN: begin
                next_q.rail = q.rail & ~hit;
                if (q.step == rail_seq_pkg::STEP_FIRST) begin
                    next_q.fsm = rail_seq_pkg::SEQ_OFF;
                end else begin
                    t_load     = 1'b1;
                    t_cycles   = gap_cycles(4'(q.step - 4'h1),
                                            i_step_delay_select, 1'b1,
                                            i_power_down_delay_factor);
                    next_q.fsm = rail_seq_pkg::SEQ_WAIT_DN;
                end
            end
            rail_seq_pkg::SEQ_WAIT_DN: begin
                if (i_power_request) begin
                    next_q.fsm = rail_seq_pkg::SEQ_STROBE_UP;
                end else if (t_done) begin
                    next_q.step = q.step - 4'h1;
                    next_q.fsm  = rail_seq_pkg::SEQ_STROBE_DN;
                end
            end
        endcase

        // Rails left out of the sequence follow their direct enable
        for (int i = 0; i < rail_seq_pkg::NUM_RAILS; i++) begin
            if (!sequenced[i]) begin
                next_q.rail[i] = i_direct_enable[i];
            end
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            q <= RESET_STATE;
        end else begin
            q <= next_q;
        end
    end

    assign o_reg_rdata   = q.rdata;
    assign o_rail_enable = q.rail;
    assign o_seq_step    = q.step;
    assign o_seq_busy    = (q.fsm != rail_seq_pkg::SEQ_OFF) &&
                           (q.fsm != rail_seq_pkg::SEQ_ON);

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (i_reset);

    logic [23:0] base_up;
    logic [23:0] base_dn;
    assign base_up = i_step_delay_select[4'(q.step - 4'h1)] ?
                     LONG_DELAY_CYCLES : SHORT_DELAY_CYCLES;
    assign base_dn = i_step_delay_select[4'(q.step - 4'h2)] ?
                     LONG_DELAY_CYCLES : SHORT_DELAY_CYCLES;

    a_step_enables_rail: assert property (
        (q.fsm == rail_seq_pkg::SEQ_STROBE_UP) && hit[0]
        |=> o_rail_enable[0])
        else $error("rail not enabled at its step");

    a_unsequenced_follows: assert property (
        !sequenced[3] && !$past(i_reset) |=>
        o_rail_enable[3] == $past(i_direct_enable[3]))
        else $error("unsequenced rail changed by sequencer");

    a_reset_buck12: assert property (
        $fell(i_reset) |-> q.buck12[3:0] == 4'h8)
        else $error("first buck field reset wrong");

    a_reset_bb_buck3: assert property (
        $fell(i_reset) |-> (q.bb_buck3[7:4] == 4'h7) &&
        (q.bb_buck3[3:0] == 4'h5))
        else $error("buck-boost or third buck reset wrong");

    a_reset_lin_gpo: assert property (
        $fell(i_reset) |-> (q.linear == 8'h63) && (q.gpo == 8'h03))
        else $error("linear or general output register reset wrong");

    a_slot_reads_zero: assert property (
        i_reg_read && (i_reg_addr == rail_seq_pkg::ADDR_SLOT) |=>
        (o_reg_rdata & 8'hCC) == 8'h00)
        else $error("reserved slot bits not zero");

    a_write_lands: assert property (
        i_reg_write && i_unlocked &&
        (i_reg_addr == rail_seq_pkg::ADDR_BB_BUCK3) |=>
        q.bb_buck3 == $past(i_reg_wdata))
        else $error("unlocked write did not land");

    a_locked_write_kept: assert property (
        i_reg_write && !i_unlocked |=>
        $stable({q.buck12, q.bb_buck3, q.slot, q.linear, q.gpo}))
        else $error("locked write changed a register");

    a_gap_up_length: assert property (
        t_load && (q.fsm == rail_seq_pkg::SEQ_STROBE_UP) |->
        t_cycles == base_up)
        else $error("power-up gap length wrong");

    a_gap_dn_factor: assert property (
        t_load && (q.fsm == rail_seq_pkg::SEQ_STROBE_DN) |->
        t_cycles == (i_power_down_delay_factor ?
                     24'(base_dn * 10) : base_dn))
        else $error("power-down gap length wrong");

    a_down_reverse: assert property (
        (q.fsm == rail_seq_pkg::SEQ_WAIT_DN) && t_done &&
        !i_power_request |=>
        (q.fsm == rail_seq_pkg::SEQ_STROBE_DN) &&
        (q.step == $past(q.step) - 4'h1))
        else $error("power-down did not step back by one");

    a_down_disables: assert property (
        (q.fsm == rail_seq_pkg::SEQ_STROBE_DN) && hit[4] |=>
        !o_rail_enable[4])
        else $error("rail not disabled at its power-down step");

    c_reach_on: cover property (
        (q.fsm == rail_seq_pkg::SEQ_STROBE_UP) &&
        (q.step == rail_seq_pkg::STEP_LAST) ##1
        (q.fsm == rail_seq_pkg::SEQ_ON));

    c_reach_off: cover property (
        (q.fsm == rail_seq_pkg::SEQ_STROBE_DN) &&
        (q.step == rail_seq_pkg::STEP_FIRST) ##1
        (q.fsm == rail_seq_pkg::SEQ_OFF));

    c_locked_write: cover property (i_reg_write && !i_unlocked);

    c_abort_up: cover property (
        (q.fsm == rail_seq_pkg::SEQ_WAIT_UP) && !i_power_request);

endmodule : rail_strobe_assignment

`default_nettype wire

// *** dv/rail_strobe_assignment_tb.sv ***
// Self-checking bench for the rail step registers and the rail sequencer
`timescale 1ns/1ps
`default_nettype none

module rail_strobe_assignment_tb;

    // ****************************************************************
    // Bench signals
    // ****************************************************************
    // Short gaps keep each sweep to a few hundred cycles, a few thousand with the factor
    localparam logic [23:0] SHORT = 24'h00_0014;
    localparam logic [23:0] LONG  = 24'h00_0032;
    localparam int          BOUND = 8000;

    logic       i_ref_clk;
    logic       i_reset;
    logic [7:0] i_reg_addr;
    logic [7:0] i_reg_wdata;
    logic       i_reg_write;
    logic       i_reg_read;
    logic       i_unlocked;
    logic [8:0] i_step_delay_select;
    logic       i_power_down_delay_factor;
    logic       i_power_request;
    logic [6:0] i_direct_enable;
    logic [7:0] o_reg_rdata;
    logic [6:0] o_rail_enable;
    logic [3:0] o_seq_step;
    logic       o_seq_busy;
    int         num_errors = 0;
    int         cmp_count  = 0;
    int         cyc        = 0;
    int         rise [7];
    int         fall [7];
    int         nchg [7];
    logic [6:0] prev_en    = 7'h00;
    int         code_of [7] = '{3, 4, 5, 6, 7, 9, 10};

    rail_strobe_assignment #(
        .SHORT_DELAY_CYCLES (SHORT),
        .LONG_DELAY_CYCLES  (LONG)
    ) dut (
        .i_ref_clk                 (i_ref_clk),
        .i_reset                   (i_reset),
        .i_reg_addr                (i_reg_addr),
        .i_reg_wdata               (i_reg_wdata),
        .i_reg_write               (i_reg_write),
        .i_reg_read                (i_reg_read),
        .i_unlocked                (i_unlocked),
        .i_step_delay_select       (i_step_delay_select),
        .i_power_down_delay_factor (i_power_down_delay_factor),
        .i_power_request           (i_power_request),
        .i_direct_enable           (i_direct_enable),
        .o_reg_rdata               (o_reg_rdata),
        .o_rail_enable             (o_rail_enable),
        .o_seq_step                (o_seq_step),
        .o_seq_busy                (o_seq_busy)
    );

    initial begin
        i_ref_clk = 1'b0;
        forever #2.5 i_ref_clk = ~i_ref_clk;
    end

    always @(posedge i_ref_clk) begin
        cyc <= cyc + 1;
    end

    // Edge times of every rail enable, sampled away from the clock edge
    always @(negedge i_ref_clk) begin
        for (int r = 0; r < 7; r++) begin
            if (o_rail_enable[r] !== prev_en[r]) begin
                nchg[r]++;
                if (o_rail_enable[r] === 1'b1) rise[r] = cyc;
                else fall[r] = cyc;
            end
        end
        prev_en = o_rail_enable;
    end

    // ****************************************************************
    // Tasks
    // ****************************************************************
    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : summarize

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        i_reg_addr  = a;
        i_reg_wdata = d;
        i_reg_write = 1'b1;
        @(negedge i_ref_clk);
        i_reg_write = 1'b0;
        // Idle cycle, so a following call never re-raises in this step
        @(negedge i_ref_clk);
    endtask : wr

    // Read data lands on the edge that takes the strobe
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        i_reg_addr = a;
        i_reg_read = 1'b1;
        @(negedge i_ref_clk);
        i_reg_read = 1'b0;
        check($sformatf("reg_%h", a), o_reg_rdata, exp);
        @(negedge i_ref_clk);
    endtask : rd

    task automatic wait_busy(input logic val);
        int n;
        n = 0;
        while (o_seq_busy !== val) begin
            if (n == BOUND) begin
                num_errors++;
                $display("mismatch busy expected %b seen timeout", val);
                summarize();
            end
            n++;
            @(negedge i_ref_clk);
        end
    endtask : wait_busy

    // One full power-up sweep followed by one full power-down sweep
    task automatic sweep(input logic [8:0] sel, input logic f);
        // Let a pending direct-enable edge reach the monitor before clearing
        repeat (2) @(negedge i_ref_clk);
        i_step_delay_select       = sel;
        i_power_down_delay_factor = f;
        for (int r = 0; r < 7; r++) begin
            nchg[r] = 0;
            rise[r] = -1;
            fall[r] = -1;
        end
        i_power_request = 1'b1;
        wait_busy(1'b1);
        wait_busy(1'b0);
        check("step on", o_seq_step, 4'hA);
        repeat (2) @(negedge i_ref_clk);
        i_power_request = 1'b0;
        wait_busy(1'b1);
        wait_busy(1'b0);
        check("step off", o_seq_step, 4'h1);
        repeat (2) @(negedge i_ref_clk);
    endtask : sweep

    // Cycles from strobe a to strobe b: one strobe cycle plus each gap
    function automatic int gsum(input int a, input int b,
                                input logic [8:0] sel, input logic dn,
                                input logic f);
        int s;
        s = 0;
        for (int k = a; k < b; k++) begin
            s += 1 + (sel[k-1] ? int'(LONG) : int'(SHORT))
                   * ((dn && f) ? 10 : 1);
        end
        return s;
    endfunction : gsum

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        logic [8:0] sel;
        logic       f;
        int         e;
        i_reset                   = 1'b1;
        i_reg_addr                = 8'h00;
        i_reg_wdata               = 8'h00;
        i_reg_write               = 1'b0;
        i_reg_read                = 1'b0;
        i_unlocked                = 1'b0;
        i_step_delay_select       = 9'h000;
        i_power_down_delay_factor = 1'b0;
        i_power_request           = 1'b0;
        i_direct_enable           = 7'h00;
        repeat (6) @(negedge i_ref_clk);
        i_reset = 1'b0;
        @(negedge i_ref_clk);
        rd(8'h22, 8'h98);
        rd(8'h23, 8'h75);
        rd(8'h24, 8'h12);
        rd(8'h25, 8'h63);
        rd(8'h26, 8'h03);
        rd(8'h27, 8'h00);
        $display("test reset_values done");
        wr(8'h23, 8'hA4);
        rd(8'h23, 8'h75);
        i_unlocked = 1'b1;
        wr(8'h23, 8'hA4);
        rd(8'h23, 8'hA4);
        wr(8'h24, 8'hFF);
        rd(8'h24, 8'h33);
        wr(8'h25, 8'h9C);
        rd(8'h25, 8'h9C);
        wr(8'h26, 8'hF0);
        rd(8'h26, 8'hF0);
        wr(8'h27, 8'h55);
        rd(8'h27, 8'h00);
        $display("test register_access done");
        // Every code on the first buck rail, timed against step three
        wr(8'h23, 8'h00);
        wr(8'h25, 8'h63);
        wr(8'h26, 8'h00);
        for (int c = 0; c < 16; c++) begin
            i_direct_enable = 7'h00;
            wr(8'h22, 8'h00);
            wr(8'h22, 8'(c));
            i_direct_enable = (c >= 3 && c <= 10) ? 7'h00 : 7'h01;
            sweep(9'h000, 1'b0);
            if (c >= 3 && c <= 10) begin
                e = gsum(3, c, 9'h000, 1'b0, 1'b0);
                check("code rise", rise[0] - rise[4], e);
                e = gsum(3, c, 9'h000, 1'b1, 1'b0);
                check("code fall", fall[4] - fall[0], e);
            end else begin
                check("unsequenced changes", nchg[0], 0);
                check("unsequenced level", o_rail_enable[0], 1);
            end
        end
        $display("test code_decode done");
        // Distinct step on every rail, both gap lengths, both factors
        // Clear direct enables first: a newly sequenced rail keeps its level
        i_direct_enable = 7'h00;
        wr(8'h22, 8'h43);
        wr(8'h23, 8'h65);
        wr(8'h25, 8'h67);
        wr(8'h26, 8'hA9);
        for (int t = 0; t < 2; t++) begin
            sel = (t == 1) ? 9'h0AA : 9'h155;
            f   = (t == 1);
            sweep(sel, f);
            for (int r = 0; r < 6; r++) begin
                e = gsum(code_of[r], code_of[r+1], sel, 1'b0, f);
                check("up gap", rise[r+1] - rise[r], e);
                e = gsum(code_of[r], code_of[r+1], sel, 1'b1, f);
                check("down gap", fall[r] - fall[r+1], e);
            end
        end
        $display("test step_timing done");
        // Reversal in mid gap, first on the way up, then on the way down
        i_step_delay_select       = 9'h000;
        i_power_down_delay_factor = 1'b0;
        i_power_request           = 1'b1;
        wait_busy(1'b1);
        repeat (70) @(negedge i_ref_clk);
        check("up abort rails", o_rail_enable, 7'h03);
        i_power_request = 1'b0;
        wait_busy(1'b0);
        check("up abort off", o_rail_enable, 7'h00);
        check("up abort step", o_seq_step, 4'h1);
        i_power_request = 1'b1;
        wait_busy(1'b1);
        wait_busy(1'b0);
        i_power_request = 1'b0;
        wait_busy(1'b1);
        repeat (30) @(negedge i_ref_clk);
        check("down abort rails", o_rail_enable, 7'h1F);
        i_power_request = 1'b1;
        wait_busy(1'b0);
        check("down abort on", o_rail_enable, 7'h7F);
        check("down abort step", o_seq_step, 4'hA);
        i_power_request = 1'b0;
        wait_busy(1'b1);
        wait_busy(1'b0);
        $display("test reversal done");
        // Reset in the middle of a power-up sweep
        i_power_request = 1'b1;
        wait_busy(1'b1);
        repeat (80) @(negedge i_ref_clk);
        i_reset = 1'b1;
        @(negedge i_ref_clk);
        check("enables in reset", o_rail_enable, 7'h00);
        check("busy in reset", o_seq_busy, 1'b0);
        i_power_request = 1'b0;
        i_reset         = 1'b0;
        @(negedge i_ref_clk);
        rd(8'h22, 8'h98);
        rd(8'h26, 8'h03);
        $display("test midrun_reset done");
        summarize();
    end

endmodule : rail_strobe_assignment_tb

`default_nettype wire
